/* logic/dimming_pkg.sv */
// Constants, register map and lookup helpers for the PWM dimming block.
package dimming_pkg;

	// ==========================================================
	// Frame layout
	// ==========================================================
	localparam int          FRAME_BITS      = 16;
	localparam int          ADDR_MSB        = 15;
	localparam int          ADDR_LSB        = 12;
	localparam int          WATCHDOG_BIT    = 11;
	localparam int          PHASE_MSB       = 10;
	localparam int          PHASE_LSB       = 9;
	localparam int          ON_BIT          = 8;
	localparam int          DUTY_MSB        = 7;
	localparam int          DUTY_LSB        = 0;
	localparam int          SUB_SEL_BIT     = 10;

	// ==========================================================
	// Register addresses
	// ==========================================================
	localparam logic [3:0]  ADDR_INIT2      = 4'h1;
	localparam logic [3:0]  ADDR_CH_FIRST   = 4'h2;
	localparam logic [3:0]  ADDR_CH_LAST    = 4'h7;
	localparam logic [3:0]  ADDR_OUT_CTRL   = 4'h8;
	localparam logic [3:0]  ADDR_GLOBAL     = 4'h9;
	localparam logic [3:0]  ADDR_IN_ENABLE  = 4'hB;
	localparam logic [3:0]  ADDR_PRESCALE   = 4'hC;
	localparam logic [3:0]  ADDR_INCR       = 4'hE;

	// ==========================================================
	// Field positions inside the shared registers
	// ==========================================================
	localparam int          RESYNC_BIT      = 1;
	localparam int          OUT_ON_LSB      = 0;
	localparam int          OUT_SKIP_LSB    = 6;
	localparam int          SEL_LO_LSB      = 0;
	localparam int          SEL_HI_LSB      = 4;
	localparam int          STEP_DIR_BIT    = 10;
	localparam int          STEP_SIZE_LSB   = 0;
	localparam int          STAT_CLK_FAIL   = 15;
	localparam int          STAT_FAIL_MODE  = 14;

	// ==========================================================
	// Reset values and duty figures
	// ==========================================================
	localparam logic [7:0]  DUTY_RESET      = 8'h00;
	localparam logic [7:0]  DUTY_FULL       = 8'hFF;
	localparam logic [7:0]  DUTY_SKIP_LOW   = 8'hF7;
	localparam logic [7:0]  DUTY_SKIP_MIN   = 8'hF8;
	localparam logic [1:0]  DIV_RESET       = 2'h0;
	localparam logic [1:0]  PHASE_RESET     = 2'h0;
	localparam logic [8:0]  STEP_4          = 9'h004;
	localparam logic [8:0]  STEP_8          = 9'h008;
	localparam logic [8:0]  STEP_16         = 9'h010;

	// ==========================================================
	// Reference clock supervision
	// ==========================================================
	localparam int          CLK_PERIOD_NS   = 5;
	localparam int          REF_MIN_PER_NS  = 9766;
	localparam int          REF_MAX_PER_NS  = 39063;
	localparam int          FAST_LIMIT_CYC  = REF_MIN_PER_NS / 2 / CLK_PERIOD_NS;
	localparam int          SLOW_LIMIT_CYC  = (REF_MAX_PER_NS * 2) / CLK_PERIOD_NS;

	// Slots of the eight-period pattern that use the lower duty.
	function automatic logic [7:0] skip_mask(input logic [7:0] duty);
		case (duty)
			8'hFE:   skip_mask = 8'h01;
			8'hFD:   skip_mask = 8'h11;
			8'hFC:   skip_mask = 8'h15;
			8'hFB:   skip_mask = 8'h55;
			8'hFA:   skip_mask = 8'h57;
			8'hF9:   skip_mask = 8'h77;
			8'hF8:   skip_mask = 8'h7F;
			default: skip_mask = 8'h00;
		endcase
	endfunction

endpackage

/* logic/pwm_channel.sv */
// One PWM channel: period position, staged duty and pulse skipping.
`timescale 1ns/1ps
module pwm_channel (
	input  wire logic       clock,          // System clock.
	input  wire logic       rst,            // Asynchronous reset, active high.
	input  wire logic [9:0] base_count,     // Shared timebase count.
	input  wire logic [1:0] divider_select, // Clock divider choice.
	input  wire logic [1:0] phase_select,   // Quarter-period phase offset.
	input  wire logic       enable,         // Effective on request.
	input  wire logic [7:0] target_duty,    // Effective duty request.
	input  wire logic       skip_enable,    // Pulse skipping allowed.
	input  wire logic       force_full,     // Modulation suspended.
	output logic            out_q           // Registered channel drive.
);

	// ==========================================================
	// Period position
	// ==========================================================
	logic [7:0] slice;
	logic [7:0] pos;
	logic [7:0] pos_prev_q;
	logic       period_start;
	logic       on_act_q;
	logic [7:0] duty_act_q;
	logic [2:0] slot_q;
	logic [7:0] mask;
	logic [7:0] eff_duty;

	// Divider and phase are read live, so changing them acts at once.
	always_comb begin
		case (divider_select)
			2'b00:   slice = base_count[9:2];
			2'b01:   slice = base_count[8:1];
			default: slice = base_count[7:0];
		endcase
		pos = slice + {phase_select, 6'h00};
	end
	assign period_start = (pos == 8'h00) && (pos_prev_q != 8'h00);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pos_prev_q <= 8'h00;
		end else begin
			pos_prev_q <= pos;
		end
	end

	// ==========================================================
	// Staged on state and duty
	// ==========================================================
	// Off and full-duty requests act at once; partial duty waits for the period start.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			on_act_q <= 1'b0;
		end else if (!enable) begin
			on_act_q <= 1'b0;
		end else if (target_duty == dimming_pkg::DUTY_FULL || period_start) begin
			on_act_q <= 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			duty_act_q <= dimming_pkg::DUTY_RESET;
		end else if (target_duty == dimming_pkg::DUTY_FULL) begin
			duty_act_q <= dimming_pkg::DUTY_FULL;
		end else if (period_start) begin
			duty_act_q <= target_duty;
		end
	end

	// Pattern slot advances once per period.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			slot_q <= 3'h0;
		end else if (period_start) begin
			slot_q <= slot_q + 3'h1;
		end
	end

	// ==========================================================
	// Output compare
	// ==========================================================
	always_comb begin
		mask = dimming_pkg::skip_mask(duty_act_q);
		eff_duty = duty_act_q;
		if (skip_enable && duty_act_q >= dimming_pkg::DUTY_SKIP_MIN) begin
			eff_duty = mask[slot_q] ? dimming_pkg::DUTY_SKIP_LOW
				: dimming_pkg::DUTY_FULL;
		end
	end

	// With a failed reference the enabled output is simply held on.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			out_q <= 1'b0;
		end else if (force_full) begin
			out_q <= enable;
		end else begin
			out_q <= on_act_q && (eff_duty == dimming_pkg::DUTY_FULL || pos < eff_duty);
		end
	end

endmodule

/* logic/dimming_control.sv */
// Multi-channel PWM dimming controller with a 16-bit SPI command port.
`timescale 1ns/1ps
module dimming_control #(
	parameter int NUM_CH     = 6,                           // Channels including external.
	parameter int SLOW_LIMIT = dimming_pkg::SLOW_LIMIT_CYC // Cycles without reference edge.
) (
	input  wire logic       clock,            // System clock, 200 MHz.
	input  wire logic       rst,              // Asynchronous reset, active high.
	input  wire logic       ref_clk_in,       // Reference PWM clock pin.
	input  wire logic       fail_mode,        // Device is in fail mode.
	input  wire logic [3:0] deglitched_input, // Direct inputs of channels 1 to 4.
	input  wire logic       sclk,             // SPI clock.
	input  wire logic       mosi,             // SPI data in.
	input  wire logic       chip_select_n,    // SPI select, active low.
	output logic            miso,             // SPI data out.
	output logic            miso_oe,          // Data out driven.
	output logic            clock_fail,       // Reference clock judged bad.
	output logic [5:0]      channel_state     // Channel drives.
);

	// The last channel drives an external switch: it takes no pulse skipping
	// and no stepped duty, so only the power channels below it get those.
	localparam int NUM_PWR = NUM_CH - 1;

	// ==========================================================
	// SPI frame capture
	// ==========================================================
	logic        sclk_q;
	logic        csn_q;
	logic [15:0] shift_in_q;
	logic [15:0] shift_out_q;
	logic [4:0]  bit_cnt_q;
	logic        frame_done;
	logic [15:0] status;
	logic [3:0]  addr;

	// A frame counts only when exactly sixteen falling clock edges came before the
	// rising select; longer or shorter frames are dropped so a glitch cannot write.
	// The counter stops at its top value so a very long frame never wraps back to 16.
	assign frame_done = chip_select_n && !csn_q && bit_cnt_q == 5'(dimming_pkg::FRAME_BITS);
	assign addr = shift_in_q[dimming_pkg::ADDR_MSB:dimming_pkg::ADDR_LSB];

	// Edge history of the SPI pins, taken as synchronous inputs.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_q <= 1'b0;
			csn_q <= 1'b1;
		end else begin
			sclk_q <= sclk;
			csn_q <= chip_select_n;
		end
	end

	// Data is sampled and the reply advanced on the falling clock edge.
	// The reply moves one bit per falling edge, so the host reads it on the rising one.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			shift_in_q <= 16'h0000;
			shift_out_q <= 16'h0000;
			bit_cnt_q <= 5'h00;
			miso <= 1'b0;
		end else if (!chip_select_n && csn_q) begin
			bit_cnt_q <= 5'h00;
			shift_out_q <= status;
			miso <= status[15];
		end else if (!chip_select_n && sclk_q && !sclk) begin
			shift_in_q <= {shift_in_q[14:0], mosi};
			shift_out_q <= {shift_out_q[14:0], 1'b0};
			miso <= shift_out_q[14];
			if (bit_cnt_q != 5'h1F) begin
				bit_cnt_q <= bit_cnt_q + 5'h01;
			end
		end
	end

	// The data line is driven only while selected, one cycle after the pin; other
	// devices on a shared line see it released one cycle after the select goes high.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			miso_oe <= 1'b0;
		end else begin
			miso_oe <= !chip_select_n;
		end
	end

	// ==========================================================
	// Register file
	// ==========================================================
	logic [7:0] duty_q [NUM_CH];
	logic [1:0] phase_q [NUM_CH];
	logic [1:0] div_q [NUM_CH];
	logic [NUM_CH-1:0]  on_q;
	logic [NUM_CH-1:0]  gsel_q;
	logic [NUM_PWR-1:0] skip_q;
	logic [3:0]  sel_lo_q;
	logic [3:0]  sel_hi_q;
	logic [7:0]  global_duty_q;
	logic        resync;

	// Resync acts at the commit edge, so several devices written with the same
	// frame restart their periods on the same select edge.
	assign resync = frame_done && addr == dimming_pkg::ADDR_INIT2
		&& shift_in_q[dimming_pkg::RESYNC_BIT];

	// Saturating step of one individual duty value.
	function automatic logic [7:0] step_duty(input logic [7:0] duty, input logic dir,
		input logic [1:0] size);
		logic [8:0] amt;
		logic [8:0] sum;
		amt = 9'h000;
		sum = 9'h000;
		case (size)
			2'b01:   amt = dimming_pkg::STEP_4;
			2'b10:   amt = dimming_pkg::STEP_8;
			2'b11:   amt = dimming_pkg::STEP_16;
			default: amt = 9'h000;
		endcase
		if (dir) begin
			sum = {1'b0, duty} + amt;
			step_duty = sum[8] ? dimming_pkg::DUTY_FULL : sum[7:0];
		end else begin
			step_duty = ({1'b0, duty} < amt) ? 8'h00 : 8'(duty - amt[7:0]);
		end
	endfunction

	// Per-channel duty, phase and on state; both registers steer the on bit.
	// Whichever of the two frames came last wins, as both hold one shared state.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				duty_q[i] <= dimming_pkg::DUTY_RESET;
				phase_q[i] <= dimming_pkg::PHASE_RESET;
			end
			on_q <= '0;
		end else if (frame_done) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (addr == 4'(int'(dimming_pkg::ADDR_CH_FIRST) + i)) begin
					duty_q[i] <= shift_in_q[dimming_pkg::DUTY_MSB:dimming_pkg::DUTY_LSB];
					phase_q[i] <= shift_in_q[dimming_pkg::PHASE_MSB:dimming_pkg::PHASE_LSB];
					on_q[i] <= shift_in_q[dimming_pkg::ON_BIT];
				end
				if (addr == dimming_pkg::ADDR_OUT_CTRL) begin
					on_q[i] <= shift_in_q[dimming_pkg::OUT_ON_LSB + i];
				end
			end
			// Stepping reads the stored individual duty, never the global value,
			// and leaves the external channel alone.
			if (addr == dimming_pkg::ADDR_INCR) begin
				for (int i = 0; i < NUM_PWR; i++) begin
					duty_q[i] <= step_duty(duty_q[i], shift_in_q[dimming_pkg::STEP_DIR_BIT],
						shift_in_q[dimming_pkg::STEP_SIZE_LSB + 2*i +: 2]);
				end
			end
		end
	end

	// Shared configuration registers; sub-select bit picks the half of 9 and 12.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_CH; i++) begin
				div_q[i] <= dimming_pkg::DIV_RESET;
			end
			gsel_q <= '0;
			skip_q <= '0;
			sel_lo_q <= 4'h0;
			sel_hi_q <= 4'h0;
			global_duty_q <= dimming_pkg::DUTY_RESET;
		end else if (frame_done) begin
			case (addr)
				dimming_pkg::ADDR_OUT_CTRL: begin
					skip_q <= shift_in_q[dimming_pkg::OUT_SKIP_LSB +: NUM_PWR];
				end
				dimming_pkg::ADDR_GLOBAL: begin
					if (shift_in_q[dimming_pkg::SUB_SEL_BIT]) begin
						global_duty_q <= shift_in_q[7:0];
					end else begin
						gsel_q <= shift_in_q[NUM_CH-1:0];
					end
				end
				dimming_pkg::ADDR_IN_ENABLE: begin
					sel_lo_q <= shift_in_q[dimming_pkg::SEL_LO_LSB +: 4];
					sel_hi_q <= shift_in_q[dimming_pkg::SEL_HI_LSB +: 4];
				end
				dimming_pkg::ADDR_PRESCALE: begin
					// The sub-select bit picks which three channels this frame reaches.
					for (int i = 0; i < 3; i++) begin
						if (shift_in_q[dimming_pkg::SUB_SEL_BIT]) begin
							div_q[i+3] <= shift_in_q[2*i +: 2];
						end else begin
							div_q[i] <= shift_in_q[2*i +: 2];
						end
					end
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Reference clock timebase and supervision
	// ==========================================================
	logic        ref_q;
	logic        ref_rise;
	logic [15:0] ref_per_q;
	logic [9:0]  base_count_q;

	// The reference pin is treated as synchronous; only its rising edges matter.
	assign ref_rise = ref_clk_in && !ref_q;

	// One-cycle delay of the reference pin for edge detection.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_clk_in;
		end
	end

	// Edge spacing outside the band marks the reference as failed.
	// The first edge after reset is measured from reset, not from an earlier edge.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_per_q <= 16'h0000;
			clock_fail <= 1'b1;
		end else if (ref_rise) begin
			ref_per_q <= 16'h0000;
			// An edge after a stale gap is still too slow; only a spacing inside the
			// band clears the flag, so one late edge cannot restart modulation.
			clock_fail <= (ref_per_q < 16'(dimming_pkg::FAST_LIMIT_CYC))
				|| (ref_per_q >= 16'(SLOW_LIMIT));
		end else if (ref_per_q >= 16'(SLOW_LIMIT)) begin
			clock_fail <= 1'b1;
		end else begin
			ref_per_q <= ref_per_q + 16'h0001;
		end
	end

	// One count per reference edge; dividers pick higher slices of it.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			base_count_q <= 10'h000;
		end else if (resync) begin
			base_count_q <= 10'h000;
		end else if (ref_rise) begin
			base_count_q <= base_count_q + 10'h001;
		end
	end

	// ==========================================================
	// Channel selection and PWM engines
	// ==========================================================
	logic [NUM_CH-1:0] eff_on;
	logic [7:0]        eff_duty [NUM_CH];
	logic [NUM_CH-1:0] pwm_out;
	logic              suspend;

	// Fail mode and a bad reference both stop modulation; the engines then hold
	// enabled outputs on rather than freezing them at whatever level they had.
	assign suspend = clock_fail || fail_mode;

	// Direct-input selection for channels 1-4, fail-mode takeover for all.
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			eff_on[i] = on_q[i];
			eff_duty[i] = gsel_q[i] ? global_duty_q : duty_q[i];
			if (i < 4) begin
				if (sel_hi_q[i] && sel_lo_q[i]) begin
					eff_duty[i] = (gsel_q[i] ^ deglitched_input[i])
						? global_duty_q : duty_q[i];
				end else if (sel_lo_q[i]) begin
					eff_on[i] = on_q[i] && deglitched_input[i];
				end
			end
			// Fail mode overrides every programmed setting, direct input selects included.
			if (fail_mode) begin
				eff_on[i] = (i < 4) ? deglitched_input[i] : 1'b0;
			end
		end
	end

	// Phase, divider and skip enable stay per channel whatever the duty source.
	// The external channel has no skip enable bit, so its engine gets a constant 0.
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			pwm_channel u_ch (
				.clock          (clock),
				.rst            (rst),
				.base_count     (base_count_q),
				.divider_select (div_q[g]),
				.phase_select   (phase_q[g]),
				.enable         (eff_on[g]),
				.target_duty    (eff_duty[g]),
				.skip_enable    ((g < NUM_PWR) ? skip_q[(g < NUM_PWR) ? g : 0] : 1'b0),
				.force_full     (suspend),
				.out_q          (pwm_out[g])
			);
		end
	endgenerate

	// Output register and status word returned in the next frame.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			channel_state <= 6'h00;
		end else begin
			channel_state <= pwm_out;
		end
	end

	// Status word, loaded into the reply at the start of each frame.
	always_comb begin
		status = 16'h0000;
		status[dimming_pkg::STAT_CLK_FAIL] = clock_fail;
		status[dimming_pkg::STAT_FAIL_MODE] = fail_mode;
		status[5:0] = channel_state;
	end

endmodule

/* sim/dimming_control_props.sv */
// Port-level assertions for the PWM dimming controller.
`timescale 1ns/1ps
module dimming_control_props #(
	parameter int SLOW_LIMIT = dimming_pkg::SLOW_LIMIT_CYC // Stale-reference limit.
) (
	input wire logic       clock,            // System clock.
	input wire logic       rst,              // Asynchronous reset.
	input wire logic       ref_clk_in,       // Reference clock pin.
	input wire logic       fail_mode,        // Fail mode level.
	input wire logic [3:0] deglitched_input, // Direct inputs.
	input wire logic       sclk,             // SPI clock.
	input wire logic       mosi,             // SPI data in.
	input wire logic       chip_select_n,    // SPI select.
	input wire logic       miso,             // SPI data out.
	input wire logic       miso_oe,          // Data out enable.
	input wire logic       clock_fail,       // Reference judged bad.
	input wire logic [5:0] channel_state     // Channel drives.
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	logic ref_q;
	int   since_edge;

	// ==========================================================
	// Reference edge age
	// ==========================================================
	// Delayed copy of the pin, used to spot rising edges.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_clk_in;
		end
	end

	// Saturating age counter, so a long silence never wraps back to small values.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			since_edge <= 0;
		end else if (ref_clk_in && !ref_q) begin
			since_edge <= 0;
		end else if (since_edge < SLOW_LIMIT + 100) begin
			since_edge <= since_edge + 1;
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	oe_on_select_a: assert property ($fell(chip_select_n) |-> ##[1:3] miso_oe)
		else $error("Data out not enabled after select.");
	oe_idle_a: assert property (chip_select_n [*4] |-> !miso_oe)
		else $error("Data out enabled while deselected.");
	fail_ext_off_a: assert property (fail_mode [*3] |-> channel_state[5:4] == 2'h0)
		else $error("Channels five or six on in fail mode.");
	fail_follow_a: assert property ((fail_mode && $stable(deglitched_input)) [*4]
		|-> channel_state[3:0] == deglitched_input)
		else $error("Channels one to four not following inputs in fail mode.");
	slow_fail_a: assert property (since_edge > SLOW_LIMIT + 8 |-> clock_fail)
		else $error("Silent reference not flagged.");
	slow_edge_a: assert property (ref_clk_in && !ref_q && since_edge >= SLOW_LIMIT
		|=> clock_fail)
		else $error("Late reference edge cleared the flag.");
	fail_clear_a: assert property ($fell(clock_fail) |-> since_edge < 8)
		else $error("Reference flag cleared away from an edge.");
	hold_in_fail_a: assert property ((clock_fail && !fail_mode && chip_select_n
		&& $stable(deglitched_input)) [*8] |-> $stable(channel_state))
		else $error("Outputs modulated with a failed reference.");
	status_first_a: assert property ($rose(miso_oe) && $stable(clock_fail)
		|-> miso == clock_fail)
		else $error("First status bit is not the reference flag.");
endmodule

bind dimming_control dimming_control_props #(.SLOW_LIMIT(SLOW_LIMIT)) props (
	.clock(clock),
	.rst(rst),
	.ref_clk_in(ref_clk_in),
	.fail_mode(fail_mode),
	.deglitched_input(deglitched_input),
	.sclk(sclk),
	.mosi(mosi),
	.chip_select_n(chip_select_n),
	.miso(miso),
	.miso_oe(miso_oe),
	.clock_fail(clock_fail),
	.channel_state(channel_state)
);

/* sim/spi_host.sv */
// Host model that sends 16-bit command frames and collects the status word.
`timescale 1ns/1ps
module spi_host (
	input  wire logic clock,         // Paces the bit times.
	input  wire logic miso,          // Status bit from the device.
	input  wire logic miso_oe,       // Status bit driven.
	output logic      sclk,          // Idle low between frames.
	output logic      mosi,          // Command bit.
	output logic      chip_select_n  // Frame select.
);
	localparam int HALF = 4; // Cycles per clock phase; the device needs one.

	// Idle bus at time zero.
	initial begin
		sclk = 1'b0;
		mosi = 1'b1;
		chip_select_n = 1'b1;
	end

	// One frame, most significant bit first; fewer than 16 bits makes a short frame.
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		@(negedge clock);
		chip_select_n = 1'b0;
		repeat (HALF) @(negedge clock);
		for (int i = 0; i < nbits; i++) begin
			mosi = tx[15 - i];
			sclk = 1'b1;
			repeat (HALF) @(negedge clock);
			rx = {rx[14:0], miso_oe ? miso : 1'b0};
			sclk = 1'b0;
			repeat (HALF) @(negedge clock);
		end
		// A released line does not keep showing the last bit.
		mosi = ~mosi;
		chip_select_n = 1'b1;
		repeat (HALF) @(negedge clock);
	endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the PWM dimming controller.
`timescale 1ns/1ps
module tb_top;
	// ==========================================================
	// Set-up
	// ==========================================================
	localparam int SLOW     = 4000; // Shortened stale-reference limit.
	localparam int REF_HALF = 977;  // Half reference period in cycles, near 102.4 kHz.
	typedef struct {bit st; logic [15:0] mask; logic [15:0] val;} note_t;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        ref_clk_in = 1'b0;
	logic        ref_run = 1'b0;
	logic        fail_mode = 1'b0;
	logic [3:0]  deglitched_input = 4'h0;
	logic        sclk, mosi, chip_select_n, miso, miso_oe, clock_fail;
	logic [5:0]  channel_state;
	logic [15:0] rx_word;
	logic [3:0]  pick;
	int          n_errors = 0;
	int          cmp_count = 0;
	note_t       notes[$];
	event        look_ev;

	always #2.5 clock = ~clock;

	// Reference clock, silent until the healthy-timebase part of the run.
	always begin
		@(negedge clock);
		if (ref_run) begin
			repeat (REF_HALF - 1) @(negedge clock);
			ref_clk_in = ~ref_clk_in;
		end
	end

	dimming_control #(.SLOW_LIMIT(SLOW)) dut (.clock(clock), .rst(rst), .ref_clk_in(ref_clk_in),
		.fail_mode(fail_mode), .deglitched_input(deglitched_input), .sclk(sclk), .mosi(mosi),
		.chip_select_n(chip_select_n), .miso(miso), .miso_oe(miso_oe),
		.clock_fail(clock_fail), .channel_state(channel_state));

	spi_host host (.clock(clock), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .mosi(mosi),
		.chip_select_n(chip_select_n));

	// ==========================================================
	// Notes and comparison
	// ==========================================================
	// Takes the oldest note whenever the driver announces a result.
	always @(look_ev) begin
		note_t       n;
		logic [15:0] seen;
		n = notes.pop_front();
		seen = n.st ? rx_word : {10'h000, channel_state};
		cmp_count++;
		if ((seen & n.mask) !== (n.val & n.mask)) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n.st ? "status" : "channel_state",
				n.val & n.mask, seen & n.mask);
		end
	end

	// One clock passes after each note so the watcher never misses a trigger.
	task automatic want(input bit st, input logic [15:0] mask, input logic [15:0] val);
		note_t n;
		n.st = st;
		n.mask = mask;
		n.val = val;
		notes.push_back(n);
		->look_ev;
		@(negedge clock);
	endtask

	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		host.xfer({a, d}, 16, rx_word);
		repeat (8) @(negedge clock);
	endtask

	task automatic settle();
		repeat (6) @(negedge clock);
	endtask

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Whole run is near 13.4k cycles; six times that means a hang.
	initial begin
		#400000;
		n_errors++;
		close_out();
	end

	// ==========================================================
	// Scenarios
	// ==========================================================
	initial begin
		void'($urandom(69269));
		repeat (6) @(negedge clock);
		rst = 1'b0;
		repeat (2) @(negedge clock);
		// Reset state, unmapped address, short frame: nothing may turn on.
		wr(4'h0, 12'h000);
		want(1, 16'hFFFF, 16'h8000);
		wr(4'hF, 12'hFFF);
		host.xfer(16'h803F, 15, rx_word);
		settle();
		want(0, 16'h003F, 16'h0000);
		// Without a reference every enabled channel is fully on.
		wr(4'h2, 12'h110);
		want(0, 16'h003F, 16'h0001);
		wr(4'h8, 12'h03F);
		want(0, 16'h003F, 16'h003F);
		wr(4'h8, 12'h000);
		want(0, 16'h003F, 16'h0000);
		wr(4'h3, 12'h9FF);
		want(0, 16'h003F, 16'h0002);
		// Fail mode with random direct inputs.
		wr(4'h8, 12'h03F);
		fail_mode = 1'b1;
		for (int i = 0; i < 6; i++) begin
			pick = 4'($urandom());
			deglitched_input = pick;
			settle();
			want(0, 16'h003F, {12'h000, pick});
		end
		wr(4'h0, 12'h000);
		want(1, 16'hFFFF, {12'hC00, pick});
		fail_mode = 1'b0;
		deglitched_input = 4'h0;
		// Channel one follows its direct input.
		wr(4'hB, 12'h001);
		wr(4'h8, 12'h001);
		want(0, 16'h0001, 16'h0000);
		deglitched_input = 4'h1;
		settle();
		want(0, 16'h0001, 16'h0001);
		deglitched_input = 4'h0;
		wr(4'hB, 12'h000);
		wr(4'h8, 12'h000);
		repeat (SLOW) @(negedge clock);
		// Healthy reference, counters resynchronised.
		ref_run = 1'b1;
		repeat (6 * REF_HALF) @(negedge clock);
		wr(4'h0, 12'h000);
		want(1, 16'h8000, 16'h0000);
		wr(4'h1, 12'h002);
		// Phase set while off; partial duty waits for the period start.
		wr(4'h3, 12'h5F0);
		wr(4'h7, 12'h5F0);
		want(0, 16'h0022, 16'h0000);
		wr(4'hE, 12'h7FF);
		want(0, 16'h0022, 16'h0002);
		// Global duty at full scale reaches a channel at once.
		wr(4'h4, 12'h500);
		wr(4'h9, 12'h4FF);
		wr(4'h9, 12'h004);
		want(0, 16'h0004, 16'h0004);
		// Input select 11: a high input swaps to the global duty.
		wr(4'hB, 12'h011);
		wr(4'h2, 12'h500);
		want(0, 16'h0001, 16'h0000);
		deglitched_input = 4'h1;
		settle();
		want(0, 16'h0001, 16'h0001);
		wr(4'h8, 12'h000);
		want(0, 16'h003F, 16'h0000);
		close_out();
	end
endmodule
